// [src/crs_pkg.sv]
// Purpose: Shared constants, types and register map of the readback shifter.
// Assumes: A small array of fixed size; frame and user widths set here.
// Notes:   Offsets are byte addresses on a 32-bit APB bus.
package crs_pkg;

    // Array size and stream layout.
    localparam int CRS_FRAMES         = 4;
    localparam int CRS_CFG_W          = 8;
    localparam int CRS_USER_PER_FRAME = 2;
    localparam int CRS_USER_W         = CRS_FRAMES * CRS_USER_PER_FRAME;
    localparam int CRS_STOP_BITS      = 4;
    localparam int CRS_FRAME_LEN      = 1 + CRS_CFG_W + CRS_USER_PER_FRAME
                                        + CRS_STOP_BITS;
    localparam int CRS_DUMMY_BITS     = 5;
    localparam int CRS_CRC_BITS       = 11;
    localparam int CRS_ABORT_EXTRA    = 3;
    localparam int CRS_FRAME_IDX_W    = 2;
    localparam int CRS_CNT_W          = 8;

    // Last counter values of each stream phase, and the first and last user bit positions.
    localparam logic [CRS_CNT_W-1:0] CRS_LAST_DUMMY =
        CRS_CNT_W'(CRS_DUMMY_BITS - 1);
    localparam logic [CRS_CNT_W-1:0] CRS_LAST_FRAME_POS =
        CRS_CNT_W'(CRS_FRAME_LEN - 1);
    localparam logic [CRS_CNT_W-1:0] CRS_LAST_CRC =
        CRS_CNT_W'(CRS_CRC_BITS - 1);
    localparam logic [CRS_CNT_W-1:0] CRS_LAST_ABORT =
        CRS_CNT_W'(CRS_FRAMES + CRS_ABORT_EXTRA - 1);
    localparam logic [CRS_CNT_W-1:0] CRS_USER_FIRST_POS =
        CRS_CNT_W'(1 + CRS_CFG_W);
    localparam logic [CRS_CNT_W-1:0] CRS_USER_LAST_POS =
        CRS_CNT_W'(CRS_CFG_W + CRS_USER_PER_FRAME);
    localparam logic [CRS_FRAME_IDX_W-1:0] CRS_LAST_FRAME =
        CRS_FRAME_IDX_W'(CRS_FRAMES - 1);

    // Signature generator.
    localparam logic [15:0] CRS_CRC_POLY = 16'h1021;
    localparam logic [15:0] CRS_CRC_INIT = 16'h0000;

    // Register map.
    localparam logic [7:0] CRS_CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] CRS_STATUS_OFFSET = 8'h04;
    localparam int CRS_CTRL_ABORT_BIT   = 0;
    localparam int CRS_CTRL_CAPTURE_BIT = 1;
    localparam int CRS_CTRL_CLKSRC_BIT  = 2;
    localparam int CRS_STAT_ACTIVE_BIT  = 0;
    localparam int CRS_STAT_BUSY_BIT    = 1;
    localparam int CRS_STAT_ABORT_BIT   = 2;
    localparam int CRS_STAT_FRAME_LSB   = 8;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } crs_apb_req_type;

    typedef struct packed {
        logic shift_clock_source_option;
        logic user_state_capture_option;
        logic abort_enable_option;
    } crs_options_type;

    localparam crs_options_type CRS_OPTIONS_RESET = 3'h0;

    typedef enum logic [2:0] {
        CRS_IDLE,
        CRS_ARMED,
        CRS_DUMMY,
        CRS_FRAME,
        CRS_CRC,
        CRS_ABORT
    } crs_state_type;

endpackage

// [src/crs_shifter.sv]
// Purpose: Readback sequencer that captures user nodes and shifts out the
//          configuration frames, captured bits and a check signature.
// Assumes: The shift clock is far slower than CLK_I and is sampled by it.
// Notes:   Options and status are reached over APB.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

// Rules of the document for this block and for the parts that drive it
// R1 - A rising sample request starts a new readback.
// R2 - The requester holds the request high for one shift clock period.
// R3 - An accepted request latches the internal nodes into a holding register.
// R4 - With aborts enabled, a falling request during a transfer aborts it.
// R5 - After an abort the requester keeps clocking until the flag drops.
// R6 - A new request waits three shift periods after the previous end; the sequencer accepts one as soon as it is back in CRS_IDLE.
// R7 - The active flag rises one shift clock after acceptance.
// R8 - The active flag falls together with the final data bit.
// R9 - After an abort the flag stays high until the extra clocks finish.
// R10 - Each shift clock rising edge moves exactly one bit out.
// R11 - The shift clock comes from a user net or the config clock pin.
// R12 - An option removes captured user bits from the stream.
// R13 - The stream starts with five dummy bits.
// R14 - Each frame is a zero start bit, data, then four one stop bits.
// R15 - The stream ends with eleven check signature bits.
// R16 - Config bits keep polarity; captured user bits are sent inverted.
// R17 - The clock supplier keeps the shift rate between 10 kHz and 1 MHz.
// R18 - Capture and shifting never disturb the user logic.
// R19 - Readback does not pass through chained devices.
// R20 - A test access port instruction can also start a readback.
// R21 - With capture disabled, user bit positions carry ones.
// R22 - After an abort, frame count plus three clocks with output high.
// R23 - The signature is the top eleven bits of a CCITT CRC-16.
// R24 - Request already high at configuration end starts the first readback.
// R25 - Output advances only on shift clock edges; request edges also arm or abort the sequencer, and an abort raises the flag.
module crs_shifter (
    // Clock, reset and enable
    input  wire logic                          CLK_I,
    input  wire logic                          RESET_I,
    input  wire logic                          CE_I,
    // APB slave
    input  wire crs_pkg::crs_apb_req_type      APB_REQ_I,
    output logic [31:0]                        PRDATA_O,
    output logic                               PREADY_O,
    output logic                               PSLVERR_O,
    // Readback pins from outside the clock domain
    input  wire logic                          RDCLK_I,
    input  wire logic                          CFG_CLK_I,
    input  wire logic                          SAMPLE_REQUEST_I,
    input  wire logic                          CONFIG_DONE_I,
    input  wire logic                          TAP_READBACK_I,
    output logic                               SERIAL_DATA_O,
    output logic                               TRANSFER_ACTIVE_FLAG_O,
    // Configuration memory and user node taps
    input  wire logic [crs_pkg::CRS_CFG_W-1:0] CFG_FRAME_I,
    output logic [crs_pkg::CRS_FRAME_IDX_W-1:0] CFG_FRAME_SEL_O,
    input  wire logic [crs_pkg::CRS_USER_W-1:0] USER_NODES_I
);
    import crs_pkg::*;

    // Pin order in the synchroniser vectors.
    localparam int PIN_RDCLK = 0;
    localparam int PIN_CCLK  = 1;
    localparam int PIN_TRIG  = 2;
    localparam int PIN_DONE  = 3;
    localparam int PIN_TAP   = 4;

    logic [4:0] meta;
    logic [4:0] sync;
    logic [4:0] prev;
    logic [4:0] next_meta;
    logic [4:0] next_sync;
    logic [4:0] next_prev;

    crs_options_type opts;
    crs_options_type next_opts;
    logic [31:0]     next_prdata;
    logic            next_pready;
    logic            next_pslverr;

    crs_state_type              state;
    crs_state_type              next_state;
    logic [CRS_CNT_W-1:0]       cnt;
    logic [CRS_CNT_W-1:0]       next_cnt;
    logic [CRS_FRAME_IDX_W-1:0] frame;
    logic [CRS_FRAME_IDX_W-1:0] next_frame;
    logic [CRS_USER_W-1:0]      hold;
    logic [CRS_USER_W-1:0]      next_hold;
    logic [15:0]                crc;
    logic [15:0]                next_crc;
    logic                       next_sdata;
    logic                       next_active;

    logic shift_tick;
    logic trig_rise;
    logic trig_fall;
    logic start_req;
    logic abort_req;
    logic busy;
    logic frame_bit_now;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic        b);
        logic fb;
        fb = c[15] ^ b;
        crc_step = {c[14:0], 1'b0} ^ (fb ? CRS_CRC_POLY : 16'h0000);
    endfunction

    // R14 - frame bit layout
    function automatic logic frame_bit(
        input logic [CRS_CNT_W-1:0]          pos,
        input logic [CRS_CFG_W-1:0]          cfg,
        input logic [CRS_USER_PER_FRAME-1:0] usr);
        int idx;
        idx = int'(pos);
        if (idx == 0) begin
            frame_bit = 1'b0;
        end else if (idx <= CRS_CFG_W) begin
            frame_bit = cfg[idx-1];
        end else if (idx <= CRS_CFG_W + CRS_USER_PER_FRAME) begin
            frame_bit = usr[idx-1-CRS_CFG_W];
        end else begin
            frame_bit = 1'b1;
        end
    endfunction

    // Pin synchronisers: the first stage feeds only the second.
    always_comb begin
        next_meta = {TAP_READBACK_I, CONFIG_DONE_I, SAMPLE_REQUEST_I,
                     CFG_CLK_I, RDCLK_I};
        next_sync = meta;
        next_prev = sync;
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            meta <= 5'h00;
            sync <= 5'h00;
            prev <= 5'h00;
        end else if (CE_I) begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    // R11 - shift clock source select
    // Switching the source mid-transfer may give one false edge.
    always_comb begin
        if (opts.shift_clock_source_option) begin
            shift_tick = CE_I & sync[PIN_RDCLK] & ~prev[PIN_RDCLK];
        end else begin
            shift_tick = CE_I & sync[PIN_CCLK] & ~prev[PIN_CCLK];
        end
    end

    assign trig_rise = CE_I & sync[PIN_TRIG] & ~prev[PIN_TRIG];
    assign trig_fall = CE_I & ~sync[PIN_TRIG] & prev[PIN_TRIG];
    assign busy      = (state != CRS_IDLE) && (state != CRS_ABORT);

    // R1 - request edge
    // R20 - test port start
    // R24 - start at configuration end
    assign start_req = (state == CRS_IDLE) && sync[PIN_DONE] && (trig_rise
        || (CE_I && sync[PIN_TAP] && !prev[PIN_TAP])
        || (CE_I && sync[PIN_DONE] && !prev[PIN_DONE] && sync[PIN_TRIG]));

    // R4 - abort on falling request
    assign abort_req = opts.abort_enable_option && trig_fall && busy;

    assign frame_bit_now = frame_bit(cnt, CFG_FRAME_I,
        hold[int'(frame)*CRS_USER_PER_FRAME +: CRS_USER_PER_FRAME]);

    // Readback sequencer.
    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_frame  = frame;
        next_hold   = hold;
        next_crc    = crc;
        next_sdata  = SERIAL_DATA_O;
        next_active = TRANSFER_ACTIVE_FLAG_O;
        if (start_req) begin
            // R3 - capture into holding register
            // R18 - nodes are only read
            // R16 - user bits inverted
            // R12 - user bits removable
            // R21 - ones when capture is off
            next_hold  = opts.user_state_capture_option ? ~USER_NODES_I
                                                        : {CRS_USER_W{1'b1}};
            next_state = CRS_ARMED;
        end else if (abort_req) begin
            // R9 - flag held through abort
            next_state  = CRS_ABORT;
            next_cnt    = '0;
            next_active = 1'b1;
        end else if (shift_tick) begin
            // R25 - advance on shift clock edges only
            // R10 - one bit per edge
            unique case (state)
                CRS_IDLE: begin
                    next_sdata = 1'b1;
                end
                CRS_ARMED: begin
                    // R7 - flag rises one shift clock later
                    next_active = 1'b1;
                    next_state  = CRS_DUMMY;
                    next_cnt    = '0;
                    next_frame  = '0;
                    next_crc    = CRS_CRC_INIT;
                end
                CRS_DUMMY: begin
                    // R13 - five dummy ones
                    next_sdata = 1'b1;
                    if (cnt == CRS_LAST_DUMMY) begin
                        next_state = CRS_FRAME;
                        next_cnt   = '0;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
                CRS_FRAME: begin
                    // R16 - config bits sent as loaded
                    next_sdata = frame_bit_now;
                    next_crc   = crc_step(crc, frame_bit_now);
                    if (cnt == CRS_LAST_FRAME_POS) begin
                        next_cnt = '0;
                        if (frame == CRS_LAST_FRAME) begin
                            next_state = CRS_CRC;
                        end else begin
                            next_frame = frame + 1'b1;
                        end
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
                CRS_CRC: begin
                    // R23 - top eleven CRC-16 bits
                    // R15 - eleven signature bits
                    next_sdata = crc[15];
                    next_crc   = {crc[14:0], 1'b0};
                    if (cnt == CRS_LAST_CRC) begin
                        // R8 - flag falls with last bit
                        next_active = 1'b0;
                        next_state  = CRS_IDLE;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
                CRS_ABORT: begin
                    // R22 - high output during extra clocks
                    // R5 - needs the requester's extra clocks
                    next_sdata = 1'b1;
                    if (cnt == CRS_LAST_ABORT) begin
                        next_active = 1'b0;
                        next_state  = CRS_IDLE;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
            endcase
        end
    end

    // R19 - single serial output, no chain input
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state                  <= CRS_IDLE;
            cnt                    <= '0;
            frame                  <= '0;
            hold                   <= '0;
            crc                    <= CRS_CRC_INIT;
            SERIAL_DATA_O          <= 1'b1;
            TRANSFER_ACTIVE_FLAG_O <= 1'b0;
            CFG_FRAME_SEL_O        <= '0;
        end else if (CE_I) begin
            state                  <= next_state;
            cnt                    <= next_cnt;
            frame                  <= next_frame;
            hold                   <= next_hold;
            crc                    <= next_crc;
            SERIAL_DATA_O          <= next_sdata;
            TRANSFER_ACTIVE_FLAG_O <= next_active;
            CFG_FRAME_SEL_O        <= next_frame;
        end
    end

    // APB slave: one access cycle, answer registered from the setup cycle.
    always_comb begin
        next_opts    = opts;
        next_pready  = 1'b0;
        next_prdata  = PRDATA_O;
        next_pslverr = 1'b0;
        if (APB_REQ_I.psel && !APB_REQ_I.penable && !PREADY_O) begin
            next_pready = 1'b1;
            next_prdata = 32'h0000_0000;
            if (APB_REQ_I.paddr == CRS_CTRL_OFFSET) begin
                next_prdata[CRS_CTRL_ABORT_BIT] = opts.abort_enable_option;
                next_prdata[CRS_CTRL_CAPTURE_BIT] =
                    opts.user_state_capture_option;
                next_prdata[CRS_CTRL_CLKSRC_BIT] =
                    opts.shift_clock_source_option;
            end else if (APB_REQ_I.paddr == CRS_STATUS_OFFSET) begin
                next_prdata[CRS_STAT_ACTIVE_BIT] = TRANSFER_ACTIVE_FLAG_O;
                next_prdata[CRS_STAT_BUSY_BIT]   = state != CRS_IDLE;
                next_prdata[CRS_STAT_ABORT_BIT]  = state == CRS_ABORT;
                next_prdata[CRS_STAT_FRAME_LSB +: CRS_FRAME_IDX_W] = frame;
            end else begin
                next_pslverr = 1'b1;
            end
        end
        if (APB_REQ_I.psel && APB_REQ_I.penable && PREADY_O
            && APB_REQ_I.pwrite && APB_REQ_I.paddr == CRS_CTRL_OFFSET) begin
            next_opts.abort_enable_option =
                APB_REQ_I.pwdata[CRS_CTRL_ABORT_BIT];
            next_opts.user_state_capture_option =
                APB_REQ_I.pwdata[CRS_CTRL_CAPTURE_BIT];
            next_opts.shift_clock_source_option =
                APB_REQ_I.pwdata[CRS_CTRL_CLKSRC_BIT];
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            opts      <= CRS_OPTIONS_RESET;
            PRDATA_O  <= 32'h0000_0000;
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else if (CE_I) begin
            opts      <= next_opts;
            PRDATA_O  <= next_prdata;
            PREADY_O  <= next_pready;
            PSLVERR_O <= next_pslverr;
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    sequence s_accept;
        start_req && CE_I;
    endsequence

    sequence s_last_crc;
        state == CRS_CRC && cnt == CRS_LAST_CRC && shift_tick && !abort_req;
    endsequence

    request_start_a: assert property ( // R1
        (state == CRS_IDLE && trig_rise && sync[PIN_DONE])
        |=> state == CRS_ARMED)
        else $error("Request edge did not arm the readback.");

    capture_hold_a: assert property ( // R3
        s_accept ##1 opts.user_state_capture_option == $past(
            opts.user_state_capture_option)
        |-> hold == (opts.user_state_capture_option ? ~$past(USER_NODES_I)
                                                    : {CRS_USER_W{1'b1}}))
        else $error("Holding register does not match the captured nodes.");

    flag_rise_a: assert property ( // R7
        (state == CRS_ARMED && shift_tick && !abort_req)
        |=> TRANSFER_ACTIVE_FLAG_O && state == CRS_DUMMY)
        else $error("Active flag did not rise on the shift edge.");

    flag_fall_a: assert property ( // R8
        s_last_crc ##1 1'b1
        |-> !TRANSFER_ACTIVE_FLAG_O && SERIAL_DATA_O == $past(crc[15]))
        else $error("Active flag did not fall with the last bit.");

    abort_entry_a: assert property ( // R4
        (abort_req && !start_req && CE_I)
        |=> state == CRS_ABORT && TRANSFER_ACTIVE_FLAG_O)
        else $error("Falling request did not abort the readback.");

    abort_flag_a: assert property ( // R9
        state == CRS_ABORT |-> TRANSFER_ACTIVE_FLAG_O)
        else $error("Active flag dropped during abort clocks.");

    one_bit_a: assert property ( // R10
        $changed(SERIAL_DATA_O) |-> $past(shift_tick))
        else $error("Serial output changed without a shift edge.");

    dummy_ones_a: assert property ( // R13
        (state == CRS_DUMMY && shift_tick && !abort_req)
        |=> SERIAL_DATA_O)
        else $error("Dummy bit was not one.");

    start_zero_a: assert property ( // R14
        (state == CRS_FRAME && cnt == '0 && shift_tick && !abort_req)
        |=> !SERIAL_DATA_O)
        else $error("Frame start bit was not zero.");

    user_ones_a: assert property ( // R21
        (state == CRS_FRAME && shift_tick && !abort_req
         && hold == {CRS_USER_W{1'b1}} && cnt >= CRS_USER_FIRST_POS
         && cnt <= CRS_USER_LAST_POS) |=> SERIAL_DATA_O)
        else $error("User position did not carry one.");

    abort_high_a: assert property ( // R22
        (state == CRS_ABORT && shift_tick) |=> SERIAL_DATA_O)
        else $error("Serial output low during abort clocks.");

    auto_start_a: assert property ( // R24
        (state == CRS_IDLE && CE_I && sync[PIN_DONE] && !prev[PIN_DONE]
         && sync[PIN_TRIG]) |=> state == CRS_ARMED)
        else $error("Configuration end did not start the readback.");

endmodule

// [tb/crs_tester.sv]
// Purpose: Far-side tester that clocks the readback link and records it.
// Assumes: Output bits settle well within half a shift clock period.
// Notes:   The shift clock stands still low between calls of pulses.
`timescale 1ns/1ps
module crs_tester (
    // Bench clock that paces the shift clock
    input  wire logic clk_i,
    // Shift clock towards the device
    output logic      clk_o,
    // Readback pins from the device
    input  wire logic data_i,
    input  wire logic flag_i
);
    logic data_q[$];
    logic flag_q[$];

    initial clk_o = 1'b0;

    // shift period fixed
    // The period is sixteen system clocks, scaled with the fast bench clock.
    task automatic pulses(input int n);
        data_q.delete();
        flag_q.delete();
        repeat (n) begin
            repeat (8) @(posedge clk_i);
            clk_o <= 1'b1;
            repeat (8) @(posedge clk_i);
            clk_o <= 1'b0;
            // Sampling at the low edge leaves the synchroniser time to land.
            data_q.push_back(data_i);
            flag_q.push_back(flag_i);
        end
    endtask
endmodule

// [tb/test_config_readback_shifter.sv]
// Purpose: Self-checking bench for the readback shifter.
// Assumes: The tester drives the shift clock; the bench drives all else.
// Notes:   Expected streams are rebuilt here from the frame layout.
`timescale 1ns/1ps
module test_config_readback_shifter;
    import crs_pkg::*;
    logic                       clk, rst, lclk, src, req, done, tap;
    logic                       ce, rdclk, cfgclk;
    logic [CRS_CFG_W-1:0]       cfg_word;
    logic                       pready, pslverr, sdata, flag;
    logic [31:0]                prdata, rdata;
    logic                       rerr;
    crs_apb_req_type            apb;
    logic [CRS_FRAME_IDX_W-1:0] sel;
    logic [CRS_USER_W-1:0]      nodes;
    logic [CRS_CFG_W-1:0]       cfg_mem [CRS_FRAMES];
    int                         error_cnt, comparisons, k;

    // The unused source sits low, so a wrongly chosen source gives no stream.
    assign rdclk    = src & lclk;
    assign cfgclk   = !src & lclk;
    assign cfg_word = cfg_mem[sel];

    crs_shifter uut (.CLK_I(clk), .RESET_I(rst), .CE_I(ce),
        .APB_REQ_I(apb), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .RDCLK_I(rdclk), .CFG_CLK_I(cfgclk),
        .SAMPLE_REQUEST_I(req), .CONFIG_DONE_I(done),
        .TAP_READBACK_I(tap), .SERIAL_DATA_O(sdata),
        .TRANSFER_ACTIVE_FLAG_O(flag), .CFG_FRAME_I(cfg_word),
        .CFG_FRAME_SEL_O(sel), .USER_NODES_I(nodes));
    crs_tester tst (.clk_i(clk), .clk_o(lclk), .data_i(sdata),
        .flag_i(flag));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] d);
        int i;
        @(posedge clk) apb <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk) apb.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rdata = prdata;
        rerr = pslverr;
        apb <= '0;
        if (i == 20) begin
            error_cnt++;
            test_done();
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic check_stream(input logic cap);
        logic [15:0]           crc;
        logic [CRS_USER_W-1:0] hold;
        logic                  b;
        int                    f, p;
        hold = cap ? ~nodes : '1;
        crc = CRS_CRC_INIT;
        for (p = 0; p < 6; p++) chk(tst.data_q[p], 1'b1);
        for (f = 0; f < CRS_FRAMES; f++) begin
            for (p = 0; p < CRS_FRAME_LEN; p++) begin
                b = (p == 0) ? 1'b0 : (p < 9) ? cfg_mem[f][p-1] :
                    (p < 11) ? hold[2*f+p-9] : 1'b1;
                chk(tst.data_q[6+15*f+p], b);
                crc = {crc[14:0], 1'b0}
                      ^ ((b ^ crc[15]) ? CRS_CRC_POLY : 16'h0000);
            end
        end
        for (p = 0; p < 11; p++) chk(tst.data_q[66+p], crc[15-p]);
        for (p = 0; p < 77; p++) chk(tst.flag_q[p], p < 76);
    endtask

    initial begin
        #200000;
        error_cnt++;
        test_done();
    end

    initial begin
        error_cnt = 0;
        comparisons = 0;
        apb = '0;
        {src, req, tap} = 3'h0;
        ce = 1'b1;
        done = 1'b1;
        nodes = 8'h5a;
        cfg_mem = '{8'h96, 8'h0f, 8'hc3, 8'h01};
        rst = 1'b1;
        wait_clk(2);
        rst <= 1'b0;
        wait_clk(1);
        chk(sdata, 1'b1);
        chk(flag, 1'b0);
        apb_xfer(1'b0, CRS_CTRL_OFFSET, 0);
        chk(rdata, 0);
        $display("test reset done");
        apb_xfer(1'b1, CRS_CTRL_OFFSET, 32'h2);
        apb_xfer(1'b0, CRS_CTRL_OFFSET, 0);
        chk(rdata, 32'h2);
        apb_xfer(1'b1, CRS_STATUS_OFFSET, 32'hff);
        apb_xfer(1'b0, CRS_STATUS_OFFSET, 0);
        chk({rdata, rerr}, 0);
        apb_xfer(1'b0, 8'h08, 0);
        chk({rdata, rerr}, 1);
        $display("test registers done");
        req <= 1'b1;
        wait_clk(10);
        tst.pulses(77);
        check_stream(1'b1);
        req <= 1'b0;
        tst.pulses(3);
        for (k = 0; k < 3; k++) chk({tst.data_q[k], tst.flag_q[k]}, 2'h2);
        $display("test capture stream done");
        apb_xfer(1'b1, CRS_CTRL_OFFSET, 32'h4);
        src <= 1'b1;
        nodes <= 8'h3c;
        tap <= 1'b1;
        wait_clk(10);
        tst.pulses(77);
        check_stream(1'b0);
        tap <= 1'b0;
        tst.pulses(3);
        $display("test tap stream done");
        apb_xfer(1'b1, CRS_CTRL_OFFSET, 32'h5);
        done <= 1'b0;
        req <= 1'b1;
        wait_clk(10);
        tst.pulses(2);
        chk(tst.flag_q[1], 1'b0);
        done <= 1'b1;
        wait_clk(10);
        tst.pulses(10);
        chk(tst.flag_q[9], 1'b1);
        // With the enable low the shift edges are lost and the falling request waits.
        ce <= 1'b0;
        req <= 1'b0;
        tst.pulses(2);
        chk(tst.data_q[1], cfg_mem[0][2]);
        chk(tst.flag_q[1], 1'b1);
        ce <= 1'b1;
        wait_clk(10);
        tst.pulses(7);
        for (k = 0; k < 7; k++) chk(tst.data_q[k], 1'b1);
        for (k = 0; k < 7; k++) chk(tst.flag_q[k], k < 6);
        $display("test abort done");
        test_done();
    end
endmodule
